// [src/ports_defs.vh]
// constants for the dual cpu parallel port block
// assumes a 32-bit axi4-lite register bus with byte addresses
`ifndef PORTS_DEFS_VH
`define PORTS_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses, bits 7:0)
// ----------------------------------------
`define OFF_IRQ_CTRL  8'h10
`define OFF_IPC       8'h14
`define OFF_FLAG_CLR  8'h18
`define OFF_BUS_CTRL  8'h1c
`define OFF_PE        8'h20
`define OFF_PG        8'h24
`define PORT_BASE     8'h40
`define PORT_STRIDE   8'h08
`define PORT_DIR_OFF  8'h04
`define CPU_SEL_BIT   8

// ----------------------------------------
// bus control fields
// ----------------------------------------
`define BC_NIB0_LO    0
`define BC_NIB0_HI    1
`define BC_NIB1_LO    2
`define BC_NIB1_HI    3
`define BC_HOST_C     4
`define BC_MUX_D      5
`define BC_TMR_A      6
`define BC_TMR_B      7
`define BC_HOST_IRQ   8
`define BUS_CTRL_RST  9'h00f

// ----------------------------------------
// interrupt status / clear fields
// ----------------------------------------
`define IRQ_EN_RISE   0
`define IRQ_EN_FALL   1
`define IRQ_EN_LEVEL  2
`define IRQ_EN_IPC    3
`define FLG_RISE      4
`define FLG_FALL      5
`define FLG_LEVEL     6
`define FLG_IPC       7
`define FLAG_CLR_READ 8'hff

// ----------------------------------------
// pin positions in the flattened port vectors
// ----------------------------------------
`define PC_LSB        16
`define PD_LSB        24
`define PF_LSB        32
`define PF_TMR_A_BIT  35
`define PF_TMR_B_BIT  36
`define PF_HOST_IRQ   39

`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// [src/irq_pin_sync.v]
// two-stage synchroniser and edge detector for interrupt pins
// assumes pins may change at any time relative to aclk
`default_nettype none

module irq_pin_sync #(
	parameter N = 3
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [N-1:0] pin_in,
	output wire [N-1:0] level,
	output wire [N-1:0] rise,
	output wire [N-1:0] fall
);

	// edges count only once the chain holds real pin samples,
	// else a low pin would look like a fall right after reset
	reg [2:0] fill_r;

	always @(posedge aclk) begin
		if (!aresetn)
			fill_r <= 3'b000;
		else
			fill_r <= {fill_r[1:0], 1'b1};
	end

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : pin_g
			reg meta_r;
			reg sync_r;
			reg prev_r;
			// first stage feeds only the second one
			always @(posedge aclk) begin
				if (!aresetn) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
					prev_r <= 1'b1;
				end else begin
					meta_r <= pin_in[g];
					sync_r <= meta_r;
					prev_r <= sync_r;
				end
			end
			assign level[g] = sync_r;
			assign rise[g]  = sync_r & ~prev_r & fill_r[2];
			assign fall[g]  = ~sync_r & prev_r & fill_r[2];
		end
	endgenerate

endmodule // irq_pin_sync

`default_nettype wire

// [src/axil_regif.v]
// axi4-lite slave front end, turns bus cycles into strobes
// assumes one outstanding write and one outstanding read
`default_nettype none
`include "ports_defs.vh"

module axil_regif #(
	parameter AW = 9
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [AW-1:0] awaddr,
	input  wire          awvalid,
	output reg           awready,
	input  wire [31:0]   wdata,
	input  wire [3:0]    wstrb,
	input  wire          wvalid,
	output reg           wready,
	output reg  [1:0]    bresp,
	output reg           bvalid,
	input  wire          bready,
	input  wire [AW-1:0] araddr,
	input  wire          arvalid,
	output reg           arready,
	output reg  [31:0]   rdata,
	output reg  [1:0]    rresp,
	output reg           rvalid,
	input  wire          rready,
	output wire          wr_en,
	output reg  [AW-1:0] wr_addr,
	output reg  [31:0]   wr_data,
	output reg  [3:0]    wr_strb,
	input  wire          wr_ok,
	output reg           rd_en,
	output reg  [AW-1:0] rd_addr,
	input  wire [31:0]   rd_data,
	input  wire          rd_ok
);

	// address and data held until both present and the last reply is gone
	assign wr_en = ~awready & ~wready & ~bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
			wr_addr <= {AW{1'b0}};
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready  <= 1'b0;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				awready <= 1'b1;
				wready  <= 1'b1;
				bvalid  <= 1'b1;
				bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rd_en   <= 1'b0;
			rd_addr <= {AW{1'b0}};
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= `RESP_OKAY;
		end else begin
			rd_en <= 1'b0;
			if (arvalid && arready) begin
				arready <= 1'b0;
				rd_addr <= araddr;
				rd_en   <= 1'b1;
			end
			if (rd_en) begin
				rvalid <= 1'b1;
				rdata  <= rd_data;
				rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule // axil_regif

`default_nettype wire

// [src/dual_cpu_ports.v]
// parallel ports and port f interrupt logic shared by two cpus
// assumes address bit 8 names the accessing cpu and pins are resolved outside
//
// Notes on behaviour
// - direction one drives pin from held latch
// - direction zero makes pin an input
// - port reads return pin levels, outputs too
// - inputs unlatched, placed on bus when selected
// - output and input only ports lack direction
// - per cpu two bits grant port a nibble writes
// - half permission writes leave other half alone
// - port c host bus, port d muxed bus
// - rising pin edge sets status bit 4
// - rise flag and enable bit 0 interrupt
// - falling edge sets bit 5, enable bit 1
// - each cpu keeps its own enables
// - bit 6 follows level pin low
// - level flag and enable bit 2 interrupt
// - cpu interrupt disable blocks all requests
// - level enable zero leaves only internal sources
// - port f pins for timers and host irq
// - zero bits clear flags, reads return ones
// - write to 0x14 flags the other cpu
// - level flag ignores software clear
`default_nettype none
`include "ports_defs.vh"

module dual_cpu_ports #(
	parameter AW = 9
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [AW-1:0] awaddr,
	input  wire          awvalid,
	output wire          awready,
	input  wire [31:0]   wdata,
	input  wire [3:0]    wstrb,
	input  wire          wvalid,
	output wire          wready,
	output wire [1:0]    bresp,
	output wire          bvalid,
	input  wire          bready,
	input  wire [AW-1:0] araddr,
	input  wire          arvalid,
	output wire          arready,
	output wire [31:0]   rdata,
	output wire [1:0]    rresp,
	output wire          rvalid,
	input  wire          rready,
	input  wire [7:0]    pa_in,
	output wire [7:0]    pa_out,
	output wire [7:0]    pa_oe,
	input  wire [7:0]    pb_in,
	output wire [7:0]    pb_out,
	output wire [7:0]    pb_oe,
	input  wire [7:0]    pc_in,
	output wire [7:0]    pc_out,
	output wire [7:0]    pc_oe,
	input  wire [7:0]    pd_in,
	output wire [7:0]    pd_out,
	output wire [7:0]    pd_oe,
	input  wire [7:0]    pf_in,
	output wire [7:0]    pf_out,
	output wire [7:0]    pf_oe,
	output reg  [7:0]    pe_out,
	input  wire [3:0]    pg_in,
	input  wire [7:0]    host_data_out,
	input  wire          host_data_oe,
	input  wire [7:0]    ext_ad_out,
	input  wire          ext_ad_oe,
	input  wire          timer_a_ext_out,
	input  wire          timer_a_ext_oe,
	input  wire          timer_b_ext_out,
	input  wire          timer_b_ext_oe,
	input  wire          host_irq_req,
	input  wire          cpu0_i_flag,
	input  wire          cpu1_i_flag,
	input  wire          cpu0_int_src,
	input  wire          cpu1_int_src,
	output reg           cpu0_irq,
	output reg           cpu1_irq
);

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	wire          wr_en;
	wire [AW-1:0] wr_addr;
	wire [31:0]   wr_data;
	wire [3:0]    wr_strb;
	wire          rd_en;
	wire [AW-1:0] rd_addr;
	reg  [31:0]   rd_data;
	reg           rd_ok;
	reg           wr_ok;

	axil_regif #(
		.AW(AW)
	) u_regif (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
	);

	wire       wr_cpu = wr_addr[`CPU_SEL_BIT];
	wire       rd_cpu = rd_addr[`CPU_SEL_BIT];
	wire [7:0] wr_off = wr_addr[7:0];
	wire [7:0] rd_off = rd_addr[7:0];
	wire       wr_lo  = wr_en & wr_strb[0];

	// decodes a word offset to known or not
	function mapped;
		input [7:0] off;
		integer k;
		begin
			mapped = (off == `OFF_IRQ_CTRL) | (off == `OFF_IPC) | (off == `OFF_FLAG_CLR)
				| (off == `OFF_BUS_CTRL) | (off == `OFF_PE) | (off == `OFF_PG);
			for (k = 0; k < 5; k = k + 1) begin
				if (off == `PORT_BASE + k * `PORT_STRIDE)
					mapped = 1'b1;
				if (off == `PORT_BASE + k * `PORT_STRIDE + `PORT_DIR_OFF)
					mapped = 1'b1;
			end
		end
	endfunction

	always @* begin
		wr_ok = mapped(wr_off);
		rd_ok = mapped(rd_off);
	end

	// ----------------------------------------
	// bus control and port e
	// ----------------------------------------
	reg [8:0] bus_ctrl_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			bus_ctrl_r <= `BUS_CTRL_RST;
			pe_out     <= 8'h00;
		end else begin
			if (wr_lo && wr_off == `OFF_BUS_CTRL)
				bus_ctrl_r <= wr_data[8:0];
			if (wr_lo && wr_off == `OFF_PE)
				pe_out <= wr_data[7:0];
		end
	end

	// per cpu nibble grant; each ungranted nibble stays put
	wire [1:0] nib_sel = wr_cpu ? {bus_ctrl_r[`BC_NIB1_HI], bus_ctrl_r[`BC_NIB1_LO]}
		: {bus_ctrl_r[`BC_NIB0_HI], bus_ctrl_r[`BC_NIB0_LO]};
	wire [7:0] nib_mask = {{4{nib_sel[1]}}, {4{nib_sel[0]}}};

	// ----------------------------------------
	// bidirectional port latches and directions
	// ----------------------------------------
	wire [39:0] lat_all;
	wire [39:0] dir_all;
	wire [39:0] pin_in_all = {pf_in, pd_in, pc_in, pb_in, pa_in};

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : port_g
			localparam [31:0] D_ADR = `PORT_BASE + g * `PORT_STRIDE;
			localparam [7:0]  D_OFF = D_ADR[7:0];
			localparam [7:0]  R_OFF = D_OFF + `PORT_DIR_OFF;
			wire [7:0] mask = (g == 0) ? nib_mask : 8'hff;
			reg  [7:0] lat_r;
			reg  [7:0] dir_r;
			always @(posedge aclk) begin
				if (!aresetn) begin
					lat_r <= 8'h00;
					dir_r <= 8'h00;
				end else begin
					if (wr_lo && wr_off == D_OFF)
						lat_r <= (lat_r & ~mask) | (wr_data[7:0] & mask);
					if (wr_lo && wr_off == R_OFF)
						dir_r <= wr_data[7:0];
				end
			end
			assign lat_all[g*8 +: 8] = lat_r;
			assign dir_all[g*8 +: 8] = dir_r;
		end
	endgenerate

	// ----------------------------------------
	// pin drive with alternate functions
	// ----------------------------------------
	reg [39:0] out_nxt;
	reg [39:0] oe_nxt;
	reg [39:0] pin_out_r;
	reg [39:0] pin_oe_r;

	always @* begin
		out_nxt = lat_all;
		oe_nxt  = dir_all;
		if (bus_ctrl_r[`BC_HOST_C]) begin
			out_nxt[`PC_LSB +: 8] = host_data_out;
			oe_nxt[`PC_LSB +: 8]  = {8{host_data_oe}};
		end
		if (bus_ctrl_r[`BC_MUX_D]) begin
			out_nxt[`PD_LSB +: 8] = ext_ad_out;
			oe_nxt[`PD_LSB +: 8]  = {8{ext_ad_oe}};
		end
		if (bus_ctrl_r[`BC_TMR_A]) begin
			out_nxt[`PF_TMR_A_BIT] = timer_a_ext_out;
			oe_nxt[`PF_TMR_A_BIT]  = timer_a_ext_oe;
		end
		if (bus_ctrl_r[`BC_TMR_B]) begin
			out_nxt[`PF_TMR_B_BIT] = timer_b_ext_out;
			oe_nxt[`PF_TMR_B_BIT]  = timer_b_ext_oe;
		end
		// open drain: pulled low only while the request stands
		if (bus_ctrl_r[`BC_HOST_IRQ]) begin
			out_nxt[`PF_HOST_IRQ] = 1'b0;
			oe_nxt[`PF_HOST_IRQ]  = host_irq_req;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_r <= 40'h0;
			pin_oe_r  <= 40'h0;
		end else begin
			pin_out_r <= out_nxt;
			pin_oe_r  <= oe_nxt;
		end
	end

	assign {pf_out, pd_out, pc_out, pb_out, pa_out} = pin_out_r;
	assign {pf_oe, pd_oe, pc_oe, pb_oe, pa_oe}      = pin_oe_r;

	// ----------------------------------------
	// port f interrupt flags and enables
	// ----------------------------------------
	wire [2:0] pf_lvl;
	wire [2:0] pf_rise;
	wire [2:0] pf_fall;

	irq_pin_sync #(
		.N(3)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  (pf_in[2:0]),
		.level   (pf_lvl),
		.rise    (pf_rise),
		.fall    (pf_fall)
	);

	reg       rise_flag_r;
	reg       fall_flag_r;
	reg [1:0] ipc_flag_r;
	reg [3:0] en0_r;
	reg [3:0] en1_r;
	wire      low_flag = ~pf_lvl[2];

	wire flg_clr_wr = wr_lo & (wr_off == `OFF_FLAG_CLR);
	wire ipc_wr     = wr_en & (wr_off == `OFF_IPC);
	wire irq_cs_wr  = wr_lo & (wr_off == `OFF_IRQ_CTRL);
	wire clr_rise = flg_clr_wr & ~wr_data[`FLG_RISE];
	wire clr_fall = flg_clr_wr & ~wr_data[`FLG_FALL];
	wire clr_ipc  = flg_clr_wr & ~wr_data[`FLG_IPC];

	always @(posedge aclk) begin
		if (!aresetn) begin
			rise_flag_r <= 1'b0;
			fall_flag_r <= 1'b0;
			ipc_flag_r  <= 2'b00;
			en0_r       <= 4'h0;
			en1_r       <= 4'h0;
		end else begin
			// a set in the clearing cycle wins
			rise_flag_r <= pf_rise[0] | (rise_flag_r & ~clr_rise);
			fall_flag_r <= pf_fall[1] | (fall_flag_r & ~clr_fall);
			// each cpu flags the other, clears only its own
			ipc_flag_r[0] <= (ipc_wr & wr_cpu)
				| (ipc_flag_r[0] & ~(clr_ipc & ~wr_cpu));
			ipc_flag_r[1] <= (ipc_wr & ~wr_cpu)
				| (ipc_flag_r[1] & ~(clr_ipc & wr_cpu));
			if (irq_cs_wr && !wr_cpu)
				en0_r <= wr_data[3:0];
			if (irq_cs_wr && wr_cpu)
				en1_r <= wr_data[3:0];
		end
	end

	// level source is masked by bit 2; others count as internal
	wire req0 = (rise_flag_r & en0_r[`IRQ_EN_RISE]) | (fall_flag_r & en0_r[`IRQ_EN_FALL])
		| (low_flag & en0_r[`IRQ_EN_LEVEL]) | (ipc_flag_r[0] & en0_r[`IRQ_EN_IPC])
		| cpu0_int_src;
	wire req1 = (rise_flag_r & en1_r[`IRQ_EN_RISE]) | (fall_flag_r & en1_r[`IRQ_EN_FALL])
		| (low_flag & en1_r[`IRQ_EN_LEVEL]) | (ipc_flag_r[1] & en1_r[`IRQ_EN_IPC])
		| cpu1_int_src;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cpu0_irq <= 1'b0;
			cpu1_irq <= 1'b0;
		end else begin
			cpu0_irq <= req0 & ~cpu0_i_flag;
			cpu1_irq <= req1 & ~cpu1_i_flag;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	integer k;
	always @* begin
		rd_data = 32'h0;
		case (rd_off)
			`OFF_IRQ_CTRL: rd_data[7:0] = {ipc_flag_r[rd_cpu], low_flag, fall_flag_r,
				rise_flag_r, rd_cpu ? en1_r : en0_r};
			`OFF_FLAG_CLR: rd_data[7:0] = `FLAG_CLR_READ;
			`OFF_BUS_CTRL: rd_data[8:0] = bus_ctrl_r;
			`OFF_PG: rd_data[3:0] = pg_in;
			default: rd_data = 32'h0;
		endcase
		// pins read live, so driven bits read back too
		for (k = 0; k < 5; k = k + 1) begin
			if (rd_off == `PORT_BASE + k * `PORT_STRIDE)
				rd_data[7:0] = pin_in_all[k*8 +: 8];
			if (rd_off == `PORT_BASE + k * `PORT_STRIDE + `PORT_DIR_OFF)
				rd_data[7:0] = dir_all[k*8 +: 8];
		end
	end

endmodule // dual_cpu_ports

`default_nettype wire

// [sim/ports_chk_asserts.sv]
// assertions on the bus handshake and irq outputs of dual_cpu_ports
// assumes a bind onto dual_cpu_ports, every input named as its port
`default_nettype none
module ports_chk #(parameter AW = 9) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic [AW-1:0] araddr,
	input wire logic          rvalid,
	input wire logic          rready,
	input wire logic [31:0]   rdata,
	input wire logic [7:0]    pe_out,
	input wire logic          cpu0_i_flag,
	input wire logic          cpu0_irq,
	input wire logic          cpu1_i_flag,
	input wire logic          cpu1_int_src,
	input wire logic          cpu1_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------
	// properties
	// ------------------------------------
	property p_wr_lat; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer not two cycles on");
	property p_rd_lat; arvalid && arready |-> ##2 rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer not two cycles on");
	property p_aw_busy; awvalid && awready |=> !awready; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("second write address taken");
	property p_w_busy; wvalid && wready |=> !wready; endproperty
	a_w_busy: assert property (p_w_busy) else $error("second write data taken");
	property p_ar_busy; arvalid && arready |=> !arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("second read taken");
	property p_clr_ones; arvalid && arready && araddr[7:0] == 8'h18 |-> ##2 rdata == 32'hff;
	endproperty
	a_clr_ones: assert property (p_clr_ones) else $error("clear location not all ones");
	property p_idis; cpu0_i_flag |=> !cpu0_irq; endproperty
	a_idis: assert property (p_idis) else $error("masked cpu interrupted");
	property p_int_src; !cpu1_i_flag && cpu1_int_src |=> cpu1_irq; endproperty
	a_int_src: assert property (p_int_src) else $error("internal source ignored");
	property p_rst; $rose(aresetn) |-> !cpu0_irq && !cpu1_irq && pe_out == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	c_wr: cover property (bvalid && bready);
	c_rd: cover property (rvalid && rready);
	c_irq: cover property ($rose(cpu0_irq));
endmodule // ports_chk
`default_nettype wire

// [sim/pin_board.sv]
// board side of the port pins: drives the far end and resolves each wire
// assumes bits 39:0 are ports f,d,c,b,a; port f bit 7 carries a pull-up
`default_nettype none
module pin_board (
	input wire logic        aclk,
	input wire logic [39:0] dev_out,
	input wire logic [39:0] dev_oe,
	input wire logic [39:0] drv,
	input wire logic [39:0] drv_en,
	output logic     [39:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------
	// wire resolution
	// ------------------------------------
	logic tog = 1'b0;
	always @(posedge aclk) begin
		tog <= ~tog;
	end
	// floating lines wander each cycle so a stale level never reads back
	always @* begin
		for (int i = 0; i < 40; i++)
			if (dev_oe[i])
				pin[i] = dev_out[i];
			else if (drv_en[i])
				pin[i] = drv[i];
			else
				pin[i] = (i == 39) ? 1'b1 : tog ^ i[0];
	end
endmodule // pin_board
`default_nettype wire

// [sim/dual_cpu_ports_tb.sv]
// self-checking bench for dual_cpu_ports over axi4-lite and the pins
// assumes pin_board resolves the pins and ports_chk is bound below
`default_nettype none
module dual_cpu_ports_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------
	// signals, instances, bus tasks
	// ------------------------------------
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cpu0_int_src;
	logic        awready, wready, bvalid, arready, rvalid, cpu0_irq, cpu1_irq, cpu1_int_src;
	logic        host_data_oe, ext_ad_oe, host_irq_req, cpu0_i_flag, cpu1_i_flag;
	logic        timer_a_ext_out, timer_a_ext_oe, timer_b_ext_out, timer_b_ext_oe;
	logic [8:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb, pg_in;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  pa_in, pb_in, pc_in, pd_in, pf_in, pa_out, pb_out, pc_out, pd_out, pf_out;
	logic [7:0]  pa_oe, pb_oe, pc_oe, pd_oe, pf_oe, pe_out, host_data_out, ext_ad_out;
	logic [39:0] drv, pin;
	int          err_count, num_checks;
	dual_cpu_ports u_dual_cpu_ports (.*);
	pin_board u_pin_board (.aclk(aclk), .dev_out({pf_out, pd_out, pc_out, pb_out, pa_out}),
		.dev_oe({pf_oe, pd_oe, pc_oe, pb_oe, pa_oe}), .drv(drv),
		.drv_en({1'b0, {39{1'b1}}}), .pin(pin));
	assign {pf_in, pd_in, pc_in, pb_in, pa_in} = pin;
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [39:0] e, g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ick(input logic [1:0] e);
		chk("irq", e, {cpu1_irq, cpu0_irq});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// aw and w may be taken on different edges
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [8:0] a, input logic [31:0] e);
		rd(a);
		chk("rdata", e, rv);
	endtask
	// ------------------------------------
	// scenarios
	// ------------------------------------
	task automatic t_reset;
		chk("oe", '0, {pa_oe, pb_oe, pc_oe, pd_oe, pf_oe});
		ick(2'b00);
		for (int i = 0; i < 5; i++)
			rchk(9'h044 + 9'(i * 8), '0);
		rchk(9'h110, '0);
		rd(9'h030);
		chk("rresp", 2'b10, resp);
		wr(9'h030, 32'h0);
		chk("bresp", 2'b10, resp);
	endtask
	task automatic t_ports;
		for (int i = 0; i < 5; i++) begin
			drv <= {5{8'h3c}};
			wr(9'h044 + 9'(i * 8), 32'hf0);
			wr(9'h040 + 9'(i * 8), 32'ha5);
			rchk(9'h040 + 9'(i * 8), 32'hac);
			drv <= {5{8'hc3}};
			cyc(2);
			rchk(9'h040 + 9'(i * 8), 32'ha3);
		end
		chk("oe", {5{8'hf0}}, {pf_oe, pd_oe, pc_oe, pb_oe, pa_oe});
		chk("out", {5{8'ha0}}, {pf_out, pd_out, pc_out, pb_out, pa_out} & {5{8'hf0}});
		wr(9'h020, 32'h5c);
		cyc(1);
		chk("pe_out", 8'h5c, pe_out);
		rchk(9'h024, 32'h9);
	endtask
	task automatic t_nibble;
		logic [8:0] bc [6] = '{9'h009, 9'h009, 9'h006, 9'h006, 9'h000, 9'h00f};
		logic [8:0] ad [6] = '{9'h040, 9'h140, 9'h040, 9'h140, 9'h040, 9'h140};
		logic [7:0] dt [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h5a};
		logic [7:0] ex [6] = '{8'h0f, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h5a};
		wr(9'h044, 32'hff);
		wr(9'h040, 32'h00);
		for (int k = 0; k < 6; k++) begin
			wr(9'h01c, 32'(bc[k]));
			wr(ad[k], 32'(dt[k]));
			cyc(1);
			chk("pa_out", ex[k], pa_out);
		end
	endtask
	task automatic t_irq;
		drv[34:32] <= 3'b110;
		cyc(8);
		wr(9'h018, 32'h0);
		wr(9'h010, 32'h01);
		wr(9'h110, 32'h02);
		rchk(9'h010, 32'h01);
		drv[32] <= 1'b1;
		cyc(8);
		rchk(9'h110, 32'h12);
		ick(2'b01);
		drv[33] <= 1'b0;
		cyc(8);
		ick(2'b11);
		wr(9'h118, 32'hef);
		cyc(2);
		ick(2'b10);
		rchk(9'h018, 32'hff);
		wr(9'h010, 32'h04);
		drv[34] <= 1'b0;
		cyc(8);
		wr(9'h018, 32'h0);
		rchk(9'h010, 32'h44);
		ick(2'b01);
		cpu0_i_flag <= 1'b1;
		cpu1_int_src <= 1'b1;
		cyc(2);
		ick(2'b10);
		cpu0_i_flag <= 1'b0;
		cpu1_int_src <= 1'b0;
		drv[34] <= 1'b1;
		cyc(8);
		ick(2'b00);
		wr(9'h014, 32'h0);
		rchk(9'h110, 32'h82);
		wr(9'h018, 32'h0);
		rchk(9'h110, 32'h82);
		wr(9'h118, 32'h7f);
		rchk(9'h110, 32'h02);
	endtask
	task automatic t_alt;
		host_data_out <= 8'h5a;
		ext_ad_out <= 8'hc3;
		{host_data_oe, ext_ad_oe, timer_a_ext_out, timer_a_ext_oe} <= 4'hf;
		{timer_b_ext_oe, host_irq_req} <= 2'b11;
		wr(9'h01c, 32'h1ff);
		cyc(2);
		chk("pc", 16'h5aff, {pc_out, pc_oe});
		chk("pd", 16'hc3ff, {pd_out, pd_oe});
		chk("pf", 6'h35, {pf_out[3], pf_oe[3], pf_out[4], pf_oe[4], pf_out[7], pf_oe[7]});
		host_irq_req <= 1'b0;
		cyc(2);
		chk("pf_pull_up", 1'b1, pf_in[7]);
	endtask
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, aresetn, cpu0_int_src, cpu1_int_src} = '0;
		{host_data_oe, ext_ad_oe, host_irq_req, cpu0_i_flag, cpu1_i_flag} = '0;
		{timer_a_ext_out, timer_a_ext_oe, timer_b_ext_out, timer_b_ext_oe} = '0;
		{awaddr, araddr, wdata, host_data_out, ext_ad_out} = '0;
		wstrb = 4'hf;
		pg_in = 4'h9;
		drv = {5{8'h3c}};
		err_count = 0;
		num_checks = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_ports;
		t_nibble;
		t_irq;
		t_alt;
		stop_test;
	end
	// whole run is a few hundred cycles
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
endmodule // dual_cpu_ports_tb
bind dual_cpu_ports ports_chk #(.AW(AW)) u_ports_chk (.*);
`default_nettype wire
